// file: core/teu_top.v
// Timed event unit: two reloadable timers and sixteen capture/compare channels
//
// Summary of operation
// - Sixteen channels, one clock resolution, eight clocks in staggered operation.
// - Two independent 16-bit timers, each with its own reload register.
// - Timer clock from prescaled system clock or auxiliary timer overflow.
// - Timers may instead count external count input edges.
// - Sixteen registers, each assignable to either timer, capture or compare.
// - Each register owns one pin: capture input or compare output.
// - Capture copies the assigned timer value into the register on pin event.
// - Each capture raises that register's own interrupt request.
// - Capture edge selectable: rising, falling, or both.
// - Compare registers checked each timer step; match triggers mode action.
// - Compare mode 0: interrupt only, several per timer period.
// - Compare mode 1: pin inverts on every match, several per period.
// - Compare mode 2: interrupt only, at most one per timer period.
// - Compare mode 3: match sets pin, timer overflow clears it, once per period.
// - Double register: two registers share a pin, toggling on either match.
// - Single event option with any mode yields just one edge or pulse.
`timescale 1ns/1ps

`include "teu_defines.vh"

module teu_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  adr_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    input  wire        we_i,
    input  wire [3:0]  sel_i,
    input  wire        stb_i,
    input  wire        cyc_i,
    output reg         ack_o,
    input  wire [15:0] pin_i,
    output wire [15:0] pin_o,
    output wire [15:0] pin_oe_o,
    input  wire [1:0]  ext_cnt_i,
    input  wire        aux_ovf_i,
    output wire        irq_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [`TEU_CTRL_W-1:0] ctrl_r;
    reg  [15:0]            tcnt_r [0:1];
    reg  [15:0]            trel_r [0:1];
    reg  [1:0]             upd_r;
    reg  [1:0]             ovf_r;
    reg  [15:0]            val_r  [0:15];
    reg  [`TEU_MODE_W-1:0] mode_r [0:15];
    reg  [17:0]            stat_r;
    reg  [17:0]            mask_r;
    reg  [7:0]             dbl_r;
    reg  [15:0]            pout_r;
    reg  [8:0]             psc_r;
    reg  [15:0]            pin1_r;
    reg  [15:0]            pin2_r;
    reg  [1:0]             ext1_r;
    reg  [1:0]             ext2_r;
    reg  [1:0]             ext3_r;

    wire [15:0] cap;
    wire [15:0] evt;
    wire [15:0] tog;
    wire [15:0] setp;
    wire [15:0] clrp;
    wire [15:0] done;
    wire [15:0] togv;
    wire [15:0] oev;
    wire [1:0]  tick;
    wire [1:0]  ext_rise;
    wire        stag_ok;
    wire        acc;
    wire        wr;
    wire [31:0] wm;
    wire [31:0] wdat;
    wire [5:0]  widx;
    wire [3:0]  cidx;
    wire [31:0] wt0c;
    wire [31:0] wt1c;
    wire [31:0] wt0r;
    wire [31:0] wt1r;
    wire [31:0] wval;
    wire [31:0] wmode;
    wire [31:0] wctrl;
    wire [31:0] wmask;
    wire [31:0] wdbl;

    integer i;
    integer ip;
    integer ic;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign acc  = cyc_i & stb_i & ~ack_o;
    assign wr   = acc & we_i;
    assign wm   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wdat = dat_i & wm;
    assign widx = adr_i[7:2];
    assign cidx = adr_i[5:2];

    // Byte lane merge with the old contents
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [31:0] m;
        begin
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // Merged per lane, then cut to each register's own width
    assign wt0c  = merge({16'h0000, tcnt_r[0]}, dat_i, wm);
    assign wt1c  = merge({16'h0000, tcnt_r[1]}, dat_i, wm);
    assign wt0r  = merge({16'h0000, trel_r[0]}, dat_i, wm);
    assign wt1r  = merge({16'h0000, trel_r[1]}, dat_i, wm);
    assign wval  = merge({16'h0000, val_r[cidx]}, dat_i, wm);
    assign wmode = merge({26'h0, mode_r[cidx]}, dat_i, wm);
    assign wctrl = merge({23'h0, ctrl_r}, dat_i, wm);
    assign wmask = merge({14'h0, mask_r}, dat_i, wm);
    assign wdbl  = merge({24'h0, dbl_r}, dat_i, wm);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin1_r <= 16'h0000;
            pin2_r <= 16'h0000;
            ext1_r <= 2'h0;
            ext2_r <= 2'h0;
            ext3_r <= 2'h0;
        end else begin
            pin1_r <= pin_i;
            pin2_r <= pin1_r;
            ext1_r <= ext_cnt_i;
            ext2_r <= ext1_r;
            ext3_r <= ext2_r;
        end
    end

    assign ext_rise = ext2_r & ~ext3_r;

    // ----------------------------------------
    // Prescaler and tick selection
    // ----------------------------------------
    // Staggered operation: steps only on one of every eight clocks
    assign stag_ok = ~ctrl_r[`TEU_C_STAG] | (psc_r[2:0] == 3'h7);

    function tick_sel;
        input [2:0] s;
        input [8:0] p;
        input       aux;
        input       ext;
        begin
            case (s)
                `TEU_CK_DIV1:  tick_sel = 1'b1;
                `TEU_CK_DIV8:  tick_sel = &p[2:0];
                `TEU_CK_DIV64: tick_sel = &p[5:0];
                `TEU_CK_D512:  tick_sel = &p;
                `TEU_CK_AUX:   tick_sel = aux;
                `TEU_CK_EXT:   tick_sel = ext;
                default:       tick_sel = 1'b0;
            endcase
        end
    endfunction

    // Auxiliary overflow and external edges are events, not clocks,
    // so they bypass the stagger gate
    assign tick[0] = ctrl_r[`TEU_C_RUN0] &
                     tick_sel(ctrl_r[`TEU_C_SEL0], psc_r, aux_ovf_i, ext_rise[0]) &
                     (ctrl_r[`TEU_C_SEL0] > `TEU_CK_D512 | stag_ok);
    assign tick[1] = ctrl_r[`TEU_C_RUN1] &
                     tick_sel(ctrl_r[`TEU_C_SEL1], psc_r, aux_ovf_i, ext_rise[1]) &
                     (ctrl_r[`TEU_C_SEL1] > `TEU_CK_D512 | stag_ok);

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            psc_r <= 9'h000;
            upd_r <= 2'h0;
            ovf_r <= 2'h0;
            for (i = 0; i < 2; i = i + 1) begin
                tcnt_r[i] <= `TEU_RST16;
                trel_r[i] <= `TEU_RST16;
            end
        end else begin
            psc_r <= psc_r + 9'h001;
            for (i = 0; i < 2; i = i + 1) begin
                upd_r[i] <= tick[i];
                ovf_r[i] <= tick[i] & (tcnt_r[i] == `TEU_TMAX);
                if (tick[i]) begin
                    if (tcnt_r[i] == `TEU_TMAX)
                        tcnt_r[i] <= trel_r[i];
                    else
                        tcnt_r[i] <= tcnt_r[i] + 16'h0001;
                end
            end
            // Software write to a count wins over a tick in the same cycle
            if (wr & (widx == `TEU_A_T0CNT >> 2))
                tcnt_r[0] <= wt0c[15:0];
            if (wr & (widx == `TEU_A_T1CNT >> 2))
                tcnt_r[1] <= wt1c[15:0];
            if (wr & (widx == `TEU_A_T0REL >> 2))
                trel_r[0] <= wt0r[15:0];
            if (wr & (widx == `TEU_A_T1REL >> 2))
                trel_r[1] <= wt1r[15:0];
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_ch
            wire ts;
            assign ts = mode_r[g][`TEU_M_TSEL];
            teu_chan u_chan (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .mode_i (mode_r[g][`TEU_M_MODE]),
                .se_i   (mode_r[g][`TEU_M_SE]),
                .pin_i  (pin2_r[g]),
                .tval_i (tcnt_r[ts]),
                .upd_i  (upd_r[ts]),
                .ovf_i  (ovf_r[ts]),
                .val_i  (val_r[g]),
                .cap_o  (cap[g]),
                .evt_o  (evt[g]),
                .tog_o  (tog[g]),
                .set_o  (setp[g]),
                .clr_o  (clrp[g]),
                .done_o (done[g])
            );
            // Upper register of a pair toggles and enables the lower pin instead of its own
            if (g < 8) begin : g_lo
                assign togv[g] = tog[g] | (dbl_r[g] & tog[g+8]);
                assign oev[g]  = mode_r[g][`TEU_M_OE] | (dbl_r[g] & mode_r[g+8][`TEU_M_OE]);
            end else begin : g_hi
                assign togv[g] = tog[g] & ~dbl_r[g-8];
                assign oev[g]  = mode_r[g][`TEU_M_OE] & ~dbl_r[g-8];
            end
        end
    endgenerate

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            pout_r <= 16'h0000;
        end else begin
            for (ip = 0; ip < 16; ip = ip + 1) begin
                if (setp[ip])
                    pout_r[ip] <= 1'b1;
                else if (clrp[ip])
                    pout_r[ip] <= 1'b0;
                else if (togv[ip])
                    pout_r[ip] <= ~pout_r[ip];
            end
        end
    end

    assign pin_o    = pout_r;
    assign pin_oe_o = oev;

    // ----------------------------------------
    // Channel registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (ic = 0; ic < 16; ic = ic + 1) begin
                val_r[ic]  <= `TEU_RST16;
                mode_r[ic] <= {`TEU_MODE_W{1'b0}};
            end
        end else begin
            for (ic = 0; ic < 16; ic = ic + 1) begin
                if (done[ic])
                    mode_r[ic][`TEU_M_MODE] <= `TEU_MD_OFF;
            end
            if (wr & (adr_i[7:6] == `TEU_R_VAL))
                val_r[cidx] <= wval[15:0];
            if (wr & (adr_i[7:6] == `TEU_R_MODE))
                mode_r[cidx] <= wmode[`TEU_MODE_W-1:0];
            // Capture wins over a software write of the same register
            for (ic = 0; ic < 16; ic = ic + 1) begin
                if (cap[ic])
                    val_r[ic] <= tcnt_r[mode_r[ic][`TEU_M_TSEL]];
            end
        end
    end

    // ----------------------------------------
    // Control, status and mask
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= {`TEU_CTRL_W{1'b0}};
            stat_r <= 18'h00000;
            mask_r <= 18'h00000;
            dbl_r  <= 8'h00;
        end else begin
            if (wr & (widx == `TEU_A_CTRL >> 2))
                ctrl_r <= wctrl[`TEU_CTRL_W-1:0];
            if (wr & (widx == `TEU_A_MASK >> 2))
                mask_r <= wmask[17:0];
            if (wr & (widx == `TEU_A_DBL >> 2))
                dbl_r <= wdbl[7:0];
            // New events win over a write-one-to-clear in the same cycle
            if (wr & (widx == `TEU_A_STAT >> 2))
                stat_r <= (stat_r & ~wdat[17:0]) | {ovf_r, evt};
            else
                stat_r <= stat_r | {ovf_r, evt};
        end
    end

    assign irq_o = |(stat_r & mask_r);

    // ----------------------------------------
    // Bus answer: one wait state, unmapped reads give zero
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= acc;
            if (acc & ~we_i) begin
                if (adr_i[7:6] == `TEU_R_VAL)
                    dat_o <= {16'h0000, val_r[cidx]};
                else if (adr_i[7:6] == `TEU_R_MODE)
                    dat_o <= {26'h0, mode_r[cidx]};
                else begin
                    case ({adr_i[7:2], 2'b00})
                        `TEU_A_CTRL:  dat_o <= {23'h0, ctrl_r};
                        `TEU_A_T0CNT: dat_o <= {16'h0000, tcnt_r[0]};
                        `TEU_A_T0REL: dat_o <= {16'h0000, trel_r[0]};
                        `TEU_A_T1CNT: dat_o <= {16'h0000, tcnt_r[1]};
                        `TEU_A_T1REL: dat_o <= {16'h0000, trel_r[1]};
                        `TEU_A_STAT:  dat_o <= {14'h0, stat_r};
                        `TEU_A_MASK:  dat_o <= {14'h0, mask_r};
                        `TEU_A_DBL:   dat_o <= {24'h0, dbl_r};
                        default:      dat_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

endmodule

// file: core/teu_defines.vh
// Register map, field positions, reset values and timing figures of the timed event unit
`ifndef TEU_DEFINES_VH
`define TEU_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TEU_A_CTRL   8'h00
`define TEU_A_T0CNT  8'h04
`define TEU_A_T0REL  8'h08
`define TEU_A_T1CNT  8'h0C
`define TEU_A_T1REL  8'h10
`define TEU_A_STAT   8'h14
`define TEU_A_MASK   8'h18
`define TEU_A_DBL    8'h1C
`define TEU_R_VAL    2'b01
`define TEU_R_MODE   2'b10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TEU_C_SEL0   2:0
`define TEU_C_SEL1   5:3
`define TEU_C_RUN0   6
`define TEU_C_RUN1   7
`define TEU_C_STAG   8
`define TEU_CTRL_W   9

// ----------------------------------------
// Clock selections
// ----------------------------------------
`define TEU_CK_DIV1  3'h0
`define TEU_CK_DIV8  3'h1
`define TEU_CK_DIV64 3'h2
`define TEU_CK_D512  3'h3
`define TEU_CK_AUX   3'h4
`define TEU_CK_EXT   3'h5

// ----------------------------------------
// Channel mode fields and codes
// ----------------------------------------
`define TEU_M_MODE   2:0
`define TEU_M_TSEL   3
`define TEU_M_SE     4
`define TEU_M_OE     5
`define TEU_MODE_W   6
`define TEU_MD_OFF   3'h0
`define TEU_MD_CAPR  3'h1
`define TEU_MD_CAPF  3'h2
`define TEU_MD_CAPB  3'h3
`define TEU_MD_CMP0  3'h4
`define TEU_MD_CMP1  3'h5
`define TEU_MD_CMP2  3'h6
`define TEU_MD_CMP3  3'h7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TEU_RST16    16'h0000
`define TEU_TMAX     16'hFFFF
`define TEU_STAG_CYC 8

`endif

// file: core/teu_chan.v
// One dual purpose capture/compare channel of the timed event unit
`timescale 1ns/1ps

`include "teu_defines.vh"

module teu_chan (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [2:0]  mode_i,
    input  wire        se_i,
    input  wire        pin_i,
    input  wire [15:0] tval_i,
    input  wire        upd_i,
    input  wire        ovf_i,
    input  wire [15:0] val_i,
    output wire        cap_o,
    output wire        evt_o,
    output wire        tog_o,
    output wire        set_o,
    output wire        clr_o,
    output wire        done_o
);

    reg  pin_d_r;
    reg  once_r;
    wire rise;
    wire fall;
    wire is_cmp;
    wire lock;
    wire match;
    wire hit;

    assign rise   = pin_i & ~pin_d_r;
    assign fall   = ~pin_i & pin_d_r;
    assign cap_o  = ((mode_i == `TEU_MD_CAPR) & rise) |
                    ((mode_i == `TEU_MD_CAPF) & fall) |
                    ((mode_i == `TEU_MD_CAPB) & (rise | fall));
    assign is_cmp = mode_i[2];
    assign lock   = (mode_i == `TEU_MD_CMP2) | (mode_i == `TEU_MD_CMP3);
    // Compared only right after the timer moved, so a stopped timer
    // does not raise an endless stream of matches
    assign match  = is_cmp & upd_i & (tval_i == val_i);
    assign hit    = match & ~(lock & once_r & ~ovf_i);
    assign evt_o  = cap_o | hit;
    assign tog_o  = (mode_i == `TEU_MD_CMP1) & hit;
    assign set_o  = (mode_i == `TEU_MD_CMP3) & hit;
    assign clr_o  = (mode_i == `TEU_MD_CMP3) & ovf_i;
    assign done_o = se_i & (cap_o |
                    ((mode_i != `TEU_MD_CMP3) & hit) |
                    (clr_o & once_r));

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_d_r <= 1'b0;
            once_r  <= 1'b0;
        end else begin
            pin_d_r <= pin_i;
            if (hit & lock)
                once_r <= 1'b1;
            else if (ovf_i | ~lock)
                once_r <= 1'b0;
        end
    end

endmodule

// file: tb/teu_pad_model.sv
// Behavioural model of the pads around the sixteen channel pins
`timescale 1ns/1ps

module teu_pad_model (
    input  wire        clk_i,
    input  wire [15:0] lvl_i,
    input  wire [15:0] core_lvl_i,
    input  wire [15:0] core_oe_i,
    output wire [15:0] pad_o
);
    reg [15:0] ext_r = 16'h0000;

    // Outside sources only move just after an edge
    always @(posedge clk_i) begin
        ext_r <= lvl_i;
    end

    // A driven pad shows the unit, a released one the outside source
    assign pad_o = (core_oe_i & core_lvl_i) | (~core_oe_i & ext_r);
endmodule

// file: tb/teu_top_sva.sv
// Port level checks of the timed event unit top
`timescale 1ns/1ps

module teu_top_sva (
    input wire        clk_i,
    input wire        rst_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire        we_i,
    input wire [3:0]  sel_i,
    input wire        stb_i,
    input wire        cyc_i,
    input wire        ack_o,
    input wire [15:0] pin_i,
    input wire [15:0] pin_o,
    input wire [15:0] pin_oe_o,
    input wire [1:0]  ext_cnt_i,
    input wire        aux_ovf_i,
    input wire        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------
    // Shadows of software writes
    // ----------------------------------------
    // Partial lane writes only ever widen these, so no false firing
    wire take = cyc_i && stb_i && !ack_o && we_i;
    reg  run_r;
    reg  mask_r;
    reg  oe_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            run_r  <= 1'b0;
            mask_r <= 1'b0;
            oe_r   <= 1'b0;
        end else if (take) begin
            if (adr_i[7:2] == 6'h00 && dat_i[7:6] != 2'b00)
                run_r <= 1'b1;
            if (adr_i[7:2] == 6'h06)
                mask_r <= (sel_i != 4'hF && mask_r) || (|dat_i[17:0]);
            if (adr_i[7] && dat_i[5])
                oe_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ack_next;   cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_ack_pulse;  ack_o |=> !ack_o; endproperty
    property p_ack_cause;  $rose(ack_o) |-> $past(cyc_i && stb_i); endproperty
    property p_unmapped;   cyc_i && stb_i && !ack_o && !we_i && adr_i[7:2] == 6'h0F |=> dat_o == 32'h0; endproperty
    property p_rst_quiet;  $fell(rst_i) |-> !ack_o && !irq_o && pin_o == 16'h0 && pin_oe_o == 16'h0; endproperty
    property p_quiet_pins; !run_r |=> $stable(pin_o); endproperty
    property p_irq_masked; !mask_r |-> !irq_o; endproperty
    property p_oe_gate;    !oe_r |-> pin_oe_o == 16'h0; endproperty

    a_ack_next:   assert property (p_ack_next) else $error("no ack one cycle after request");
    a_ack_pulse:  assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause:  assert property (p_ack_cause) else $error("ack without request");
    a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
    a_rst_quiet:  assert property (p_rst_quiet) else $error("outputs not quiet after reset");
    a_quiet_pins: assert property (p_quiet_pins) else $error("pin moved with timers idle");
    a_irq_masked: assert property (p_irq_masked) else $error("irq with empty mask");
    a_oe_gate:    assert property (p_oe_gate) else $error("pin enabled without request");

    c_run:   cover property (take && adr_i[7:2] == 6'h00);
    c_irq:   cover property ($rose(irq_o));
    c_rise:  cover property ($rose(pin_o[0]));
    c_fall:  cover property ($fell(pin_o[0]));
endmodule

bind teu_top teu_top_sva u_teu_top_sva (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
    .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .ext_cnt_i(ext_cnt_i), .aux_ovf_i(aux_ovf_i), .irq_o(irq_o)
);

// file: tb/tb.sv
// Self-checking bench of the timed event unit
`timescale 1ns/1ps
`include "teu_defines.vh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  adr_i     = 8'h00;
    logic [31:0] dat_i     = 32'h0;
    logic        we_i      = 1'b0;
    logic [3:0]  sel_i     = 4'hF;
    logic        stb_i     = 1'b0;
    logic        cyc_i     = 1'b0;
    logic [1:0]  ext_cnt_i = 2'h0;
    logic        aux_ovf_i = 1'b0;
    logic [15:0] lvl       = 16'h0;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire  [15:0] pin_i;
    wire  [15:0] pin_o;
    wire  [15:0] pin_oe_o;
    wire         irq_o;
    int          n_fail     = 0;
    int          n_compared = 0;
    logic [31:0] q;

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    teu_top u_teu_top (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
        .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .ext_cnt_i(ext_cnt_i), .aux_ovf_i(aux_ovf_i), .irq_o(irq_o));

    teu_pad_model u_teu_pad_model (.clk_i(clk_i), .lvl_i(lvl), .core_lvl_i(pin_o),
        .core_oe_i(pin_oe_o), .pad_o(pin_i));

    // ----------------------------------------
    // Bus and stimulus helpers
    // ----------------------------------------
    // Holds the request until ack is seen, read data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    // One auxiliary overflow pulse, then room for the two edge pipeline
    task automatic tick;
        aux_ovf_i <= 1'b1;
        @(posedge clk_i);
        aux_ovf_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic end_sim;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [7:0] a [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h40, 8'h3C};
        `CHK({irq_o, pin_o, pin_oe_o}, 33'h0)
        wb(1'b1, 8'h3C, 32'hFFFFFFFF);
        foreach (a[i]) begin
            wb(1'b0, a[i], 32'h0);
            `CHK(q, 32'h0)
        end
        $display("test reset done");
    endtask

    task automatic t_clock;
        int e;
        for (int s = 0; s < 7; s++) begin
            wb(1'b1, `TEU_A_T0CNT, 32'h0);
            wb(1'b1, `TEU_A_CTRL, (s == 6) ? 32'h140 : (s == 4) ? 32'hE4 : (32'h40 | s));
            if (s == 4)
                repeat (5) tick;
            else if (s == 5)
                repeat (3) begin
                    ext_cnt_i[0] <= 1'b1;
                    repeat (4) @(posedge clk_i);
                    ext_cnt_i[0] <= 1'b0;
                    repeat (4) @(posedge clk_i);
                end
            else
                repeat (1024) @(posedge clk_i);
            wb(1'b1, `TEU_A_CTRL, 32'h0);
            wb(1'b0, `TEU_A_T0CNT, 32'h0);
            e = (s == 4) ? 5 : (s == 5) ? 3 : (s == 6) ? 128 : (1024 >> (3 * s));
            `CHK((q >= e) && (q <= e + ((s == 4 || s == 5) ? 0 : 4)), 1'b1)
        end
        // Second timer ran only beside the first in the auxiliary step
        wb(1'b0, `TEU_A_T1CNT, 32'h0);
        `CHK(q, 32'h5)
        $display("test clock done");
    endtask

    task automatic t_capture;
        logic [15:0] v;
        logic        hit;
        v = 16'h0;
        wb(1'b1, `TEU_A_MASK, 32'h4);
        for (int m = 1; m < 4; m++) begin
            wb(1'b1, 8'h88, 32'h8 | m);
            for (int k = 0; k < 2; k++) begin
                wb(1'b1, `TEU_A_T1CNT, 32'h1111 * (2 * m + k));
                wb(1'b1, `TEU_A_STAT, 32'h3FFFF);
                lvl[2] <= ~lvl[2];
                repeat (6) @(posedge clk_i);
                hit = (m == 3) || (m == k + 1);
                if (hit)
                    v = 16'h1111 * (2 * m + k);
                `CHK(irq_o, hit)
                wb(1'b0, `TEU_A_STAT, 32'h0);
                `CHK(q[2], hit)
                wb(1'b0, 8'h48, 32'h0);
                `CHK(q[15:0], v)
            end
        end
        wb(1'b1, `TEU_A_STAT, 32'h3FFFF);
        `CHK(irq_o, 1'b0)
        wb(1'b1, `TEU_A_MASK, 32'h0);
        $display("test capture done");
    endtask

    task automatic t_compare;
        wb(1'b1, `TEU_A_T0REL, 32'h1);
        wb(1'b1, `TEU_A_CTRL, 32'h44);
        for (int m = 4; m < 8; m++) begin
            wb(1'b1, `TEU_A_T0CNT, 32'h1);
            wb(1'b1, 8'h40, 32'h2);
            wb(1'b1, 8'h80, 32'h20 | m);
            wb(1'b1, `TEU_A_STAT, 32'h3FFFF);
            tick;
            wb(1'b0, `TEU_A_STAT, 32'h0);
            `CHK(q[0], 1'b1)
            `CHK(pin_o[0], m == 5 || m == 7)
            `CHK(pin_oe_o[0], 1'b1)
            wb(1'b1, `TEU_A_STAT, 32'h3FFFF);
            wb(1'b1, 8'h40, 32'h4);
            tick;
            tick;
            wb(1'b0, `TEU_A_STAT, 32'h0);
            `CHK(q[0], m < 6)
            `CHK(pin_o[0], m == 7)
            wb(1'b1, `TEU_A_T0CNT, 32'hFFFF);
            tick;
            wb(1'b0, `TEU_A_T0CNT, 32'h0);
            `CHK(q[15:0], 16'h1)
            wb(1'b0, `TEU_A_STAT, 32'h0);
            `CHK(q[16], 1'b1)
            `CHK(pin_o[0], 1'b0)
        end
        $display("test compare done");
    endtask

    task automatic t_single_double;
        wb(1'b1, 8'h40, 32'h2);
        wb(1'b1, 8'h80, 32'h35);
        tick;
        `CHK(pin_o[0], 1'b1)
        wb(1'b0, 8'h80, 32'h0);
        `CHK(q[2:0], 3'h0)
        wb(1'b1, `TEU_A_T0CNT, 32'h1);
        tick;
        `CHK(pin_o[0], 1'b1)
        wb(1'b1, `TEU_A_DBL, 32'h1);
        wb(1'b1, 8'h80, 32'h25);
        wb(1'b1, 8'hA0, 32'h25);
        wb(1'b1, 8'h60, 32'h3);
        wb(1'b1, `TEU_A_T0CNT, 32'h1);
        `CHK(pin_oe_o[8], 1'b0)
        tick;
        `CHK(pin_o[0], 1'b0)
        tick;
        `CHK(pin_o[0], 1'b1)
        $display("test single and double done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_clock;
        t_capture;
        t_compare;
        t_single_double;
        end_sim;
    end

    // Tests need about six thousand cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        end_sim;
    end
endmodule
